/* File: rtl/fpg_pkg.sv */
// fpg_pkg: constants and types for the flash program guard.
// assumes one 100 MHz clock domain and an AXI4-Lite register bus of 32-bit words.
package fpg_pkg;
  // flash geometry
  localparam int ADDR_W = 13;
  localparam int FLASH_BYTES = 8192;
  localparam int EXTERNAL_RAM_BYTES = 512;
  localparam int PAGE_W = 9;
  localparam logic [8:0] PAGE_LAST = 9'h1FF;
  localparam logic [12:0] LOCK_ADDR = 13'h1DFF;
  localparam logic [12:0] RESERVED_BASE = 13'h1E00;
  localparam logic [7:0] ERASED = 8'hFF;

  // unlock key values, in order
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_KEY = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_XDATA = 8'h0C;
  localparam logic [7:0] OFF_CODE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // program_store_control fields
  localparam int CTRL_WE_BIT = 0;
  localparam int CTRL_EE_BIT = 1;
  localparam int CTRL_SRC_LSB = 2;

  // status fields
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;

  // access sources
  localparam logic [1:0] SRC_DEBUG = 2'h0;
  localparam logic [1:0] SRC_UNLOCKED = 2'h1;
  localparam logic [1:0] SRC_LOCKED = 2'h2;

  // access kinds for the security check
  localparam logic [1:0] ACC_READ = 2'h0;
  localparam logic [1:0] ACC_WRITE = 2'h1;
  localparam logic [1:0] ACC_ERASE = 2'h2;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} fpg_key_t;
  typedef enum logic [2:0] {OP_BOOT, OP_BOOT_CAP, OP_IDLE, OP_FETCH, OP_PROG, OP_ERASE} fpg_op_t;
endpackage

/* File: rtl/fpg_flash_program_guard.sv */
// fpg_flash_program_guard: on-chip flash with write/erase guard, unlock keys and lock-byte security.
// assumes a single AXI4-Lite master, synchronous active-low reset, one clock.
// Overview of operation
// [RQ1] Programming can only clear bits, so the stored byte becomes old AND new; only erase sets bits.
// [RQ2] Software should check that a byte reads as 0xFF before programming it.
// [RQ3] A flash write is accepted only after the key register got 0xA5 and then 0xF1.
// [RQ4] To program, software sets write enable and clears erase enable first.
// [RQ5] One key sequence unlocks one write only; it is re-armed for every byte.
// [RQ6] An erase clears one 512-byte page and needs the keys again for each page.
// [RQ7] Flash changes only with write enable set; erase needs write and erase enable both set.
// [RQ8] A byte write is a data-move write to an address inside the flash.
// [RQ9] Data-move reads always go to the external RAM; flash is read by the code-move path.
// [RQ10] A lock byte other than 0xFF locks every page from page 0, the lock page included.
// [RQ11] While locked, accesses from the debug port and from unprotected code are blocked.
// [RQ12] Restrictions differ for debug port, code on unlocked pages and code on locked pages; the code treats debug port and unlocked-page code alike.
// [RQ13] Writes into the reserved area are refused.
// [RQ14] Erases of the reserved area, and of the lock page while locked, are refused.
// [RQ15] Software should mask interrupts around a program and clear write enable afterwards.
// [RQ16] A write without a complete, ordered key sequence leaves the flash unchanged.
module fpg_flash_program_guard (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  // storage, flash ships erased; the initialiser is no process, so the array keeps a single writer
  logic [7:0] flash_mem [fpg_pkg::FLASH_BYTES] = '{default: fpg_pkg::ERASED};
  logic [7:0] external_ram_mem [fpg_pkg::EXTERNAL_RAM_BYTES];

  // bus state
  logic aw_got, next_aw_got;
  logic w_got, next_w_got;
  logic [7:0] aw_addr, next_aw_addr;
  logic [15:0] w_data, next_w_data;
  logic [1:0] w_lane, next_w_lane;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // control and guard state
  logic ctrl_we, next_ctrl_we;
  logic ctrl_ee, next_ctrl_ee;
  logic [1:0] ctrl_src, next_ctrl_src;
  logic [12:0] flash_addr, next_flash_addr;
  fpg_pkg::fpg_key_t key_state, next_key_state;
  fpg_pkg::fpg_op_t op_state, next_op_state;
  logic [12:0] op_addr, next_op_addr;
  logic [7:0] op_data, next_op_data;
  logic [8:0] erase_cnt, next_erase_cnt;
  logic [7:0] lock_byte, next_lock_byte;
  logic refused, next_refused;

  // memory ports
  logic [7:0] rd_data;
  logic [7:0] external_ram_rd;
  logic [12:0] rd_addr;
  logic mem_we;
  logic [12:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic external_ram_we;
  logic locked;
  logic busy;

  // security decision for one access
  function automatic logic fpg_allowed(input logic [1:0] kind, input logic [1:0] src,
                                       input logic [12:0] addr, input logic lk);
    logic ok;
    ok = 1'b1;
    if (kind != fpg_pkg::ACC_READ && addr >= fpg_pkg::RESERVED_BASE) begin
      ok = 1'b0; // [RQ13] [RQ14]
    end
    if (lk) begin
      // any source code other than locked pages counts as unprotected
      if (src != fpg_pkg::SRC_LOCKED) begin
        ok = 1'b0; // [RQ11] [RQ12]
      end else if (kind == fpg_pkg::ACC_ERASE && addr[12:9] == fpg_pkg::LOCK_ADDR[12:9]) begin
        ok = 1'b0; // [RQ14]
      end
    end
    return ok;
  endfunction

  assign locked = (lock_byte != fpg_pkg::ERASED); // [RQ10]
  assign busy = (op_state != fpg_pkg::OP_IDLE);

  always_comb begin
    if (op_state == fpg_pkg::OP_BOOT) begin
      rd_addr = fpg_pkg::LOCK_ADDR;
    end else if (busy) begin
      rd_addr = op_addr;
    end else begin
      rd_addr = flash_addr;
    end
  end

  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane = w_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_ctrl_we = ctrl_we;
    next_ctrl_ee = ctrl_ee;
    next_ctrl_src = ctrl_src;
    next_flash_addr = flash_addr;
    next_key_state = key_state;
    next_op_state = op_state;
    next_op_addr = op_addr;
    next_op_data = op_data;
    next_erase_cnt = erase_cnt;
    next_lock_byte = lock_byte;
    next_refused = refused;
    mem_we = 1'b0;
    mem_waddr = op_addr;
    mem_wdata = fpg_pkg::ERASED;
    external_ram_we = 1'b0;

    // address and data may arrive in either order
    if (awready && awvalid) begin
      next_aw_got = 1'b1;
      next_aw_addr = awaddr[7:0];
    end
    if (wready && wvalid) begin
      next_w_got = 1'b1;
      next_w_data = wdata[15:0];
      next_w_lane = wstrb[1:0];
    end

    if (aw_got && w_got && !bvalid) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = fpg_pkg::RESP_OKAY;
      case (aw_addr)
        fpg_pkg::OFF_CTRL: begin
          if (w_lane[0]) begin
            next_ctrl_we = w_data[fpg_pkg::CTRL_WE_BIT];
            next_ctrl_ee = w_data[fpg_pkg::CTRL_EE_BIT];
            next_ctrl_src = w_data[fpg_pkg::CTRL_SRC_LSB +: 2];
          end
        end
        fpg_pkg::OFF_KEY: begin
          if (w_lane[0]) begin
            // a wrong or out-of-order value drops back to the start
            if (key_state == fpg_pkg::KEY_IDLE && w_data[7:0] == fpg_pkg::KEY_FIRST) begin
              next_key_state = fpg_pkg::KEY_HALF; // [RQ3]
            end else if (key_state == fpg_pkg::KEY_HALF && w_data[7:0] == fpg_pkg::KEY_SECOND) begin
              next_key_state = fpg_pkg::KEY_OPEN; // [RQ3]
            end else begin
              next_key_state = fpg_pkg::KEY_IDLE;
            end
          end
        end
        fpg_pkg::OFF_ADDR: begin
          if (w_lane[0]) begin
            next_flash_addr[7:0] = w_data[7:0];
          end
          if (w_lane[1]) begin
            next_flash_addr[12:8] = w_data[12:8];
          end
        end
        fpg_pkg::OFF_XDATA: begin
          if (busy) begin
            next_bresp = fpg_pkg::RESP_SLVERR;
          end else if (!w_lane[0]) begin
            next_bresp = fpg_pkg::RESP_OKAY;
          end else if (!ctrl_we) begin
            external_ram_we = 1'b1; // [RQ7]
          end else begin
            next_key_state = fpg_pkg::KEY_IDLE; // [RQ5] [RQ6]
            if (key_state != fpg_pkg::KEY_OPEN) begin
              next_refused = 1'b1; // [RQ16] [RQ3]
            end else if (ctrl_ee) begin
              if (fpg_allowed(fpg_pkg::ACC_ERASE, ctrl_src, flash_addr, locked)) begin
                next_op_state = fpg_pkg::OP_ERASE; // [RQ7] [RQ6]
                next_op_addr = {flash_addr[12:9], 9'h000};
                next_erase_cnt = 9'h000;
              end else begin
                next_refused = 1'b1;
              end
            end else if (fpg_allowed(fpg_pkg::ACC_WRITE, ctrl_src, flash_addr, locked)) begin
              next_op_state = fpg_pkg::OP_FETCH; // [RQ8]
              next_op_addr = flash_addr;
              next_op_data = w_data[7:0];
            end else begin
              next_refused = 1'b1;
            end
          end
        end
        fpg_pkg::OFF_CODE: begin
          next_bresp = fpg_pkg::RESP_OKAY;
        end
        fpg_pkg::OFF_STATUS: begin
          if (w_lane[0] && w_data[fpg_pkg::STAT_REFUSED_BIT]) begin
            next_refused = 1'b0;
          end
        end
        default: begin
          next_bresp = fpg_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;

    if (arready && arvalid) begin
      next_rvalid = 1'b1;
      next_rresp = fpg_pkg::RESP_OKAY;
      next_rdata = 32'h00000000;
      case (araddr[7:0])
        fpg_pkg::OFF_CTRL: begin
          next_rdata[fpg_pkg::CTRL_WE_BIT] = ctrl_we;
          next_rdata[fpg_pkg::CTRL_EE_BIT] = ctrl_ee;
          next_rdata[fpg_pkg::CTRL_SRC_LSB +: 2] = ctrl_src;
        end
        fpg_pkg::OFF_KEY: begin
          next_rdata[1:0] = key_state;
        end
        fpg_pkg::OFF_ADDR: begin
          next_rdata[12:0] = flash_addr;
        end
        fpg_pkg::OFF_XDATA: begin
          next_rdata[7:0] = external_ram_rd; // [RQ9]
        end
        fpg_pkg::OFF_CODE: begin
          if (busy) begin
            next_rresp = fpg_pkg::RESP_SLVERR;
          end else if (fpg_allowed(fpg_pkg::ACC_READ, ctrl_src, flash_addr, locked)) begin
            next_rdata[7:0] = rd_data; // [RQ9]
          end else begin
            next_refused = 1'b1; // [RQ11]
          end
        end
        fpg_pkg::OFF_STATUS: begin
          next_rdata[fpg_pkg::STAT_LOCKED_BIT] = locked;
          next_rdata[fpg_pkg::STAT_REFUSED_BIT] = refused;
          next_rdata[2] = busy;
          next_rdata[4:3] = key_state;
        end
        default: begin
          next_rresp = fpg_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;

    case (op_state)
      fpg_pkg::OP_BOOT: begin
        next_op_state = fpg_pkg::OP_BOOT_CAP;
      end
      fpg_pkg::OP_BOOT_CAP: begin
        // lock state is rebuilt from the array, which keeps its contents over reset
        next_lock_byte = rd_data; // [RQ10]
        next_op_state = fpg_pkg::OP_IDLE;
      end
      fpg_pkg::OP_FETCH: begin
        next_op_state = fpg_pkg::OP_PROG;
      end
      fpg_pkg::OP_PROG: begin
        mem_we = 1'b1;
        mem_waddr = op_addr;
        mem_wdata = rd_data & op_data; // [RQ1]
        if (op_addr == fpg_pkg::LOCK_ADDR) begin
          next_lock_byte = rd_data & op_data; // [RQ10]
        end
        next_op_state = fpg_pkg::OP_IDLE;
      end
      fpg_pkg::OP_ERASE: begin
        mem_we = 1'b1;
        mem_waddr = {op_addr[12:9], erase_cnt};
        mem_wdata = fpg_pkg::ERASED; // [RQ1] [RQ6]
        next_erase_cnt = erase_cnt + 9'h001;
        if (erase_cnt == fpg_pkg::PAGE_LAST) begin
          next_op_state = fpg_pkg::OP_IDLE;
          if (op_addr[12:9] == fpg_pkg::LOCK_ADDR[12:9]) begin
            next_lock_byte = fpg_pkg::ERASED;
          end
        end
      end
      fpg_pkg::OP_IDLE: begin
        next_op_state = next_op_state;
      end
      default: begin
        next_op_state = fpg_pkg::OP_IDLE;
      end
    endcase
  end

  // arrays have no reset: flash is non-volatile and the RAM content is undefined anyway
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      flash_mem[mem_waddr] <= mem_wdata;
    end
    if (external_ram_we) begin
      external_ram_mem[flash_addr[8:0]] <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= fpg_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= fpg_pkg::RESP_OKAY;
      rdata <= 32'h00000000;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 16'h0000;
      w_lane <= 2'h0;
      ctrl_we <= 1'b0;
      ctrl_ee <= 1'b0;
      ctrl_src <= fpg_pkg::SRC_DEBUG;
      flash_addr <= 13'h0000;
      key_state <= fpg_pkg::KEY_IDLE;
      op_state <= fpg_pkg::OP_BOOT;
      op_addr <= 13'h0000;
      op_data <= 8'h00;
      erase_cnt <= 9'h000;
      lock_byte <= 8'h00;
      refused <= 1'b0;
      rd_data <= 8'h00;
      external_ram_rd <= 8'h00;
    end else begin
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane <= next_w_lane;
      ctrl_we <= next_ctrl_we;
      ctrl_ee <= next_ctrl_ee;
      ctrl_src <= next_ctrl_src;
      flash_addr <= next_flash_addr;
      key_state <= next_key_state;
      op_state <= next_op_state;
      op_addr <= next_op_addr;
      op_data <= next_op_data;
      erase_cnt <= next_erase_cnt;
      lock_byte <= next_lock_byte;
      refused <= next_refused;
      rd_data <= flash_mem[rd_addr];
      external_ram_rd <= external_ram_mem[flash_addr[8:0]];
    end
  end

endmodule

/* File: testbench/fpg_checker_sva.sv */
// fpg_checker: port-level handshake timing and response-code checks on the guard's register bus.
// assumes it is bound into the guard and sees only the top module's ports.
module fpg_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // read address and data
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed early");
  b_answer_a: assert property (wr_taken |-> ##[1:2] bvalid)
    else $error("write response late");
  r_answer_a: assert property (rd_taken |=> rvalid)
    else $error("read answer late");
  b_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  r_block_a: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  bad_rd_a: assert property (arvalid && arready && araddr[7:0] > 8'h14 |=>
    rresp == fpg_pkg::RESP_SLVERR && rdata == 32'h0) else $error("unmapped read answered");
  xdata_rd_a: assert property (arvalid && arready && araddr[7:0] == fpg_pkg::OFF_XDATA |=>
    rresp == fpg_pkg::RESP_OKAY) else $error("data-move read refused");
  bad_wr_a: assert property (awvalid && awready && wvalid && wready && awaddr[7:0] > 8'h14 |->
    ##[1:2] (bvalid && bresp == fpg_pkg::RESP_SLVERR)) else $error("unmapped write answered");
endmodule
bind fpg_flash_program_guard fpg_checker chk (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot,
  .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
  .rvalid, .rready, .rdata, .rresp);

/* File: testbench/tb.sv */
// tb: self-checking bench for the flash program guard against a byte-level flash model.
// assumes the guard's register map and answer timing as handed over.
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0;
  logic aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, q;
  logic [1:0] r;
  int failures = 0, n_tests = 0, key = 0, rf = 0, busy = 0, i;
  integer seed = 32'h4b59;
  logic [7:0] fm [0:8191];
  logic [7:0] xr [0:511];
  logic [3:0] ctl = 0;
  logic [12:0] ad = 0, a;
  logic [3:0] cs [8] = '{1, 1, 1, 1, 1, 1, 0, 2};
  logic [7:0] k1s [8] = '{8'hA5, 8'hF1, 8'hA5, 8'h00, 8'hA5, 8'hA5, 8'hA5, 8'hA5};
  logic [7:0] k2s [8] = '{8'hF1, 8'hA5, 8'h00, 8'hF1, 8'hF1, 8'hF1, 8'hF1, 8'hF1};
  always #5 aclk = ~aclk;
  fpg_flash_program_guard dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp);
  task summarize;
    $display("failures %0d tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic lkd();
    return fm[fpg_pkg::LOCK_ADDR] != 8'hFF;
  endfunction
  // flash side of a data-move write; the key is spent by any flash attempt
  task automatic mdl(input logic [7:0] d);
    if (!ctl[0]) xr[ad[8:0]] = d;
    else begin
      if (key == 2) begin
        if (ad >= fpg_pkg::RESERVED_BASE || (lkd() && ctl[3:2] != 2'h2) || (lkd() && ctl[1] && ad[12:9] == 4'hE))
          rf = 1;
        else if (ctl[1]) begin
          for (int j = 0; j < 512; j++) fm[{ad[12:9], j[8:0]}] = 8'hFF;
          busy = 1;
        end
        else fm[ad] = fm[ad] & d;
      end
      else rf = 1;
      key = 0;
    end
  endtask
  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    logic [1:0] er;
    er = (o > 8'h14 || o[1:0] != 2'h0 || (o == 8'h0C && busy != 0)) ? fpg_pkg::RESP_SLVERR : fpg_pkg::RESP_OKAY;
    @(posedge aclk);
    awvalid <= 1;
    wvalid <= 1;
    awaddr <= {24'h0, o};
    wdata <= d;
    bready <= 1;
    for (i = 0; i < 50 && !bvalid; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end
    if (!bvalid) begin
      failures++;
      summarize();
    end
    bready <= 0;
    `CHK(bresp, er)
    case (o)
      8'h00: ctl = d[3:0];
      8'h04: key = (d[7:0] == fpg_pkg::KEY_FIRST && key == 0) ? 1 : (d[7:0] == fpg_pkg::KEY_SECOND && key == 1) ? 2 : 0;
      8'h08: ad = d[12:0];
      8'h0C: if (er == fpg_pkg::RESP_OKAY) mdl(d[7:0]);
      8'h14: if (d[1]) rf = 0;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] o);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= {24'h0, o};
    rready <= 1;
    for (i = 0; i < 50 && !rvalid; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end
    if (!rvalid) begin
      failures++;
      summarize();
    end
    q = rdata;
    r = rresp;
    rready <= 0;
  endtask
  function automatic logic [31:0] ex(input logic [7:0] o);
    case (o)
      8'h00: return {28'h0, ctl};
      8'h04: return key;
      8'h08: return {19'h0, ad};
      8'h0C: return {24'h0, xr[ad[8:0]]};
      8'h10: if (lkd() && ctl[3:2] != 2'h2) begin
        rf = 1;
        return 0;
      end
      else return {24'h0, fm[ad]};
      8'h14: return {key[1:0], busy[0], rf[0], lkd()};
      default: return 0;
    endcase
  endfunction
  task automatic chk_rd(input logic [7:0] o);
    logic [31:0] e;
    rd(o);
    e = ex(o);
    `CHK(q, e)
    `CHK(r, (o > 8'h14) ? fpg_pkg::RESP_SLVERR : fpg_pkg::RESP_OKAY)
  endtask
  // erase holds the array for hundreds of cycles, so poll status under a bound
  task automatic wait_idle;
    for (int n = 0; n < 700; n++) begin
      rd(8'h14);
      if (q[2] === 1'b0) break;
    end
    if (q[2] !== 1'b0) begin
      failures++;
      summarize();
    end
    busy = 0;
  endtask
  task automatic op(input logic [3:0] c, input logic [7:0] k1, input logic [7:0] k2, input logic [12:0] x,
    input logic [7:0] d);
    wr(8'h14, 2);
    wr(8'h00, c);
    wr(8'h04, k1);
    wr(8'h04, k2);
    chk_rd(8'h04);
    wr(8'h08, x);
    chk_rd(8'h10);
    wr(8'h0C, d);
    wait_idle();
    chk_rd(8'h04);
    chk_rd(8'h10);
    chk_rd(8'h14);
    wr(8'h04, 0);
  endtask
  initial begin
    foreach (fm[j]) fm[j] = 8'hFF;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    for (int j = 0; j < 6; j++) chk_rd(8'h04 * j[7:0]);
    chk_rd(8'h18);
    wr(8'h20, 1);
    a = 13'h200 | 13'($random(seed) & 32'h1FF);
    for (int j = 0; j < 8; j++) begin
      op(cs[j], k1s[j], k2s[j], a, 8'($random(seed)));
      wr(8'h0C, 0);
      chk_rd(8'h10);
      chk_rd(8'h0C);
    end
    op(1, 8'hA5, 8'hF1, a + 13'h200, 8'($random(seed)));
    wr(8'h14, 2);
    wr(8'h00, 3);
    wr(8'h04, 8'hA5);
    wr(8'h04, 8'hF1);
    wr(8'h08, a);
    wr(8'h0C, 0);
    wr(8'h0C, 0);
    rd(8'h10);
    `CHK(r, fpg_pkg::RESP_SLVERR)
    wait_idle();
    chk_rd(8'h10);
    wr(8'h08, a + 13'h200);
    chk_rd(8'h10);
    op(1, 8'hA5, 8'hF1, 13'h1E10, 0);
    op(3, 8'hA5, 8'hF1, 13'h1E10, 0);
    op(1, 8'hA5, 8'hF1, fpg_pkg::LOCK_ADDR, 0);
    for (int s = 0; s < 4; s++) op({s[1:0], 2'h1}, 8'hA5, 8'hF1, a, 8'($random(seed)));
    op(4'hB, 8'hA5, 8'hF1, 13'h1C00, 0);
    wr(8'h00, 0);
    chk_rd(8'h00);
    wr(8'h0C, 8'h5A);
    chk_rd(8'h0C);
    summarize();
  end
endmodule
